// ===== usart_mode_irq.sv
// Overview of operation
// - baud source: clock, clock/8, or clock pin
// - length field gives five to eight bits
// - sync bit picks asynchronous or clocked framing
// - check field: even, odd, space, mark, none, multidrop
// - stop code: 1, 1.5 async only, 2
// - loop 00: independent receiver and transmitter
// - loop 01: receive pin echoed on transmit
// - loop 10: transmitter fed into receiver
// - loop 11: receive pin wired to transmit
// - nine-bit select forces nine-bit characters
// - clock pin driven if drive set, internal
// - mode register read/write at 04, resets zero
// - enable register at 08 sets mask bits
// - disable register at 0C clears mask bits
// - mask view at 10, resets all disabled
// - ten sources share one bit layout
// - interrupt when status and mask bits meet
// - transfer channel off while nine-bit set
// - local loopback ignores rx, holds tx high
`timescale 1ns/1ps

module usart_mode_irq (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [usart_mode_pkg::ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [usart_mode_pkg::NSRC-1:0] status_i,
    input wire logic tx_bit_i,
    input wire logic rxd_i,
    input wire logic sck_i,
    output logic txd_o,
    output logic sck_o,
    output logic sck_oe_o,
    output logic rx_bit_o,
    output logic baud_tick_o,
    output usart_mode_pkg::frame_cfg_t frame_cfg_o,
    output logic tx_enable_o,
    output logic rx_enable_o,
    output logic xfer_enable_o,
    output logic irq_o
);
    import usart_mode_pkg::*;

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    logic ack_q;
    mode_cfg_t mode_q;
    logic [NSRC-1:0] mask_q;
    wire req = wb_cyc_i & wb_stb_i & ~ack_q;
    wire wr = req & wb_we_i;
    wire hit_mode = wb_adr_i == OFS_MODE;
    wire hit_set = wb_adr_i == OFS_IEN_SET;
    wire hit_clr = wb_adr_i == OFS_IEN_CLR;
    wire hit_mask = wb_adr_i == OFS_MASK;
    wire [31:0] lane = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    wire [31:0] wmask = lane & MODE_WMASK;
    wire [31:0] wbits = wb_dat_i & lane;

    // write-only registers and unmapped offsets read as zero
    wire [31:0] rd_data = hit_mode ? mode_q :
                          hit_mask ? {{(32 - NSRC){1'b0}}, mask_q} :
                          32'h0000_0000;

    // ------------------------------------------------------------
    // register updates
    // ------------------------------------------------------------
    wire [31:0] mode_d = (mode_q & ~wmask) | (wb_dat_i & wmask);
    wire [NSRC-1:0] set_bits = (wr & hit_set) ? wbits[NSRC-1:0] : MASK_RESET;
    wire [NSRC-1:0] clr_bits = (wr & hit_clr) ? wbits[NSRC-1:0] : MASK_RESET;
    // set and clear share a cycle only if both hit, which one access cannot
    wire [NSRC-1:0] mask_d = (mask_q | set_bits) & ~clr_bits;

    // one-cycle answer; reads have no side effect on the mask
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            ack_q <= req;
            wb_dat_o <= req ? rd_data : 32'h0000_0000;
        end
    end
    assign wb_ack_o = ack_q;

    // mode register, reserved bits stay zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode_q <= MODE_RESET;
        end else if (wr & hit_mode) begin
            mode_q <= mode_d;
        end
    end

    // interrupt mask, all sources off after reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mask_q <= MASK_RESET;
        end else begin
            mask_q <= mask_d;
        end
    end

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic rxd_s1, rxd_s2;
    logic sck_s1, sck_s2, sck_s3;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rxd_s1 <= 1'b1;
            rxd_s2 <= 1'b1;
            sck_s1 <= 1'b0;
            sck_s2 <= 1'b0;
            sck_s3 <= 1'b0;
        end else begin
            rxd_s1 <= rxd_i;
            rxd_s2 <= rxd_s1;
            sck_s1 <= sck_i;
            sck_s2 <= sck_s1;
            sck_s3 <= sck_s2;
        end
    end

    // ------------------------------------------------------------
    // baud source selection
    // ------------------------------------------------------------
    // one clock only: each source becomes an enable pulse
    logic [2:0] div_q;
    logic sck_q;
    wire ext_src = mode_q.baud_source_select[1];
    wire sck_rise = sck_s2 & ~sck_s3;
    wire div_wrap = div_q == DIV8_LAST;
    wire tick_d = ext_src ? sck_rise :
                  (mode_q.baud_source_select == SRC_MCK) ? 1'b1 : div_wrap;
    wire drive_d = mode_q.clock_pin_drive & ~ext_src;

    // pin clock toggles per internal tick; rate is halved, duty is exactly half
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div_q <= 3'h0;
            baud_tick_o <= 1'b0;
            sck_q <= 1'b0;
        end else begin
            div_q <= div_q + 3'h1;
            baud_tick_o <= tick_d;
            sck_q <= sck_q ^ (tick_d & ~ext_src);
        end
    end
    assign sck_o = sck_q;

    // pin released whenever the external clock is the source
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sck_oe_o <= 1'b0;
        end else begin
            sck_oe_o <= drive_d;
        end
    end

    // ------------------------------------------------------------
    // framing decode
    // ------------------------------------------------------------
    wire [3:0] len_bits = CHAR_BASE + {2'b00, mode_q.char_length_field};
    wire [2:0] chk = mode_q.check_bit_kind;
    wire [1:0] stp = mode_q.stop_bit_count;
    wire stop_rsv = (stp == 2'h3) | ((stp == STOP_ONE_HALF) & mode_q.sync_select);
    wire [2:0] halves = (stp == STOP_TWO) ? HALVES_TWO :
                        (stp == STOP_ONE_HALF) ? HALVES_ONE_HALF : HALVES_ONE;
    // low check bit is a don't-care once the top bit is set
    wire check_t chk_d = chk[2] ? check_t'({chk[2:1], 1'b0}) : check_t'(chk);
    frame_cfg_t frame_d;
    assign frame_d.data_bits = mode_q.nine_bit_char_select ? CHAR_NINE : len_bits;
    assign frame_d.sync_mode = mode_q.sync_select;
    assign frame_d.check_kind = chk_d;
    assign frame_d.stop_halves = halves;
    assign frame_d.stop_reserved = stop_rsv;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            frame_cfg_o <= '0;
            xfer_enable_o <= 1'b0;
        end else begin
            frame_cfg_o <= frame_d;
            xfer_enable_o <= ~mode_q.nine_bit_char_select;
        end
    end

    // ------------------------------------------------------------
    // channel loop routing
    // ------------------------------------------------------------
    logic txd_d, rxin_d, txen_d, rxen_d;
    always_comb begin
        txd_d = tx_bit_i;
        rxin_d = rxd_s2;
        txen_d = 1'b1;
        rxen_d = 1'b1;
        unique case (mode_q.channel_loop_mode)
            LOOP_NORMAL: begin
                txd_d = tx_bit_i;
            end
            LOOP_ECHO: begin
                txd_d = rxd_s2;
                txen_d = 1'b0;
            end
            LOOP_LOCAL: begin
                txd_d = 1'b1;
                rxin_d = tx_bit_i;
            end
            LOOP_REMOTE: begin
                txd_d = rxd_s2;
                rxin_d = 1'b1;
                txen_d = 1'b0;
                rxen_d = 1'b0;
            end
        endcase
    end

    // line idles high through reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            txd_o <= 1'b1;
            rx_bit_o <= 1'b1;
            tx_enable_o <= 1'b0;
            rx_enable_o <= 1'b0;
        end else begin
            txd_o <= txd_d;
            rx_bit_o <= rxin_d;
            tx_enable_o <= txen_d;
            rx_enable_o <= rxen_d;
        end
    end

    // ------------------------------------------------------------
    // interrupt line
    // ------------------------------------------------------------
    wire irq_d = |(status_i & mask_q);
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= irq_d;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    mode_reset_a: assert property (@(posedge clk_i) rst_i |=> mode_q == MODE_RESET)
        else $error("mode register not zero after reset");

    mask_reset_a: assert property (@(posedge clk_i) rst_i |=> mask_q == MASK_RESET)
        else $error("mask not zero after reset");

    ien_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wr && hit_set |=> ((mask_q & $past(set_bits)) == $past(set_bits)) &&
            ((mask_q & ~$past(set_bits)) == ($past(mask_q) & ~$past(set_bits))))
        else $error("enable write did not set mask bits");

    ien_clr_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wr && hit_clr |=> ((mask_q & $past(clr_bits)) == MASK_RESET) &&
            ((mask_q & ~$past(clr_bits)) == ($past(mask_q) & ~$past(clr_bits))))
        else $error("disable write did not clear mask bits");

    wo_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
        req && !wb_we_i && (hit_set || hit_clr) |=> wb_ack_o && wb_dat_o == 32'h0000_0000 &&
            $stable(mask_q))
        else $error("write-only register read not zero");

    irq_level_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ##1 irq_o == |($past(status_i) & $past(mask_q)))
        else $error("interrupt line does not follow status and mask");

    mck_tick_a: assert property (@(posedge clk_i) disable iff (rst_i)
        mode_q.baud_source_select == SRC_MCK [*2] |-> baud_tick_o)
        else $error("master clock source missed a tick");

    sck_drive_a: assert property (@(posedge clk_i) disable iff (rst_i)
        mode_q.baud_source_select[1] |=> !sck_oe_o)
        else $error("clock pin driven with external source");

    xfer_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
        mode_q.nine_bit_char_select |=> !xfer_enable_o ##1 frame_cfg_o.data_bits == CHAR_NINE ||
            !mode_q.nine_bit_char_select)
        else $error("transfer channel on with nine-bit characters");

    local_idle_a: assert property (@(posedge clk_i) disable iff (rst_i)
        mode_q.channel_loop_mode == LOOP_LOCAL |=> txd_o && rx_bit_o == $past(tx_bit_i))
        else $error("local loopback routing wrong");

    echo_path_a: assert property (@(posedge clk_i) disable iff (rst_i)
        mode_q.channel_loop_mode == LOOP_ECHO |=> txd_o == $past(rxd_s2))
        else $error("echo does not copy receive pin");

    // normal mode keeps both engines on and passes the transmitter straight out
    normal_path_a: assert property (@(posedge clk_i) disable iff (rst_i)
        mode_q.channel_loop_mode == LOOP_NORMAL |=> txd_o == $past(tx_bit_i) && tx_enable_o && rx_enable_o)
        else $error("normal mode routing wrong");

    remote_path_a: assert property (@(posedge clk_i) disable iff (rst_i)
        mode_q.channel_loop_mode == LOOP_REMOTE |=> txd_o == $past(rxd_s2) && !tx_enable_o && !rx_enable_o)
        else $error("remote loopback routing wrong");

    // the divided source must tick exactly on the divider wrap, never between
    div_tick_a: assert property (@(posedge clk_i) disable iff (rst_i)
        mode_q.baud_source_select == SRC_DIV8 |=> baud_tick_o == $past(div_wrap))
        else $error("divided clock tick out of step");

    ext_tick_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ext_src |=> baud_tick_o == $past(sck_rise))
        else $error("clock pin edge not passed to baud tick");

    len_field_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !mode_q.nine_bit_char_select |=>
            frame_cfg_o.data_bits == CHAR_BASE + $past({2'b00, mode_q.char_length_field}))
        else $error("data length does not follow length field");

    nine_len_a: assert property (@(posedge clk_i) disable iff (rst_i)
        mode_q.nine_bit_char_select |=> frame_cfg_o.data_bits == CHAR_NINE)
        else $error("nine-bit select did not give nine bits");

    sync_copy_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ##1 frame_cfg_o.sync_mode == $past(mode_q.sync_select))
        else $error("framing select not passed on");

    half_stop_a: assert property (@(posedge clk_i) disable iff (rst_i)
        mode_q.stop_bit_count == STOP_ONE_HALF && !mode_q.sync_select |=>
            frame_cfg_o.stop_halves == HALVES_ONE_HALF && !frame_cfg_o.stop_reserved)
        else $error("one and a half stop bits not decoded");

    // engines never see the odd codes of the no-check and multidrop pairs
    check_norm_a: assert property (@(posedge clk_i) disable iff (rst_i)
        mode_q.check_bit_kind[2] |=> {frame_cfg_o.check_kind} == {$past(mode_q.check_bit_kind[2:1]), 1'b0})
        else $error("check kind not normalised");

    mask_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !(wr && (hit_set || hit_clr)) |=> $stable(mask_q))
        else $error("mask changed without an enable or disable write");

    sck_on_a: assert property (@(posedge clk_i) disable iff (rst_i)
        mode_q.clock_pin_drive && !mode_q.baud_source_select[1] |=> sck_oe_o)
        else $error("clock pin not driven when asked");

endmodule : usart_mode_irq

// ===== usart_mode_pkg.sv
package usart_mode_pkg;

    // ------------------------------------------------------------
    // register map (byte offsets)
    // ------------------------------------------------------------
    localparam int ADR_W = 8;
    localparam logic [ADR_W-1:0] OFS_MODE = 8'h04;
    localparam logic [ADR_W-1:0] OFS_IEN_SET = 8'h08;
    localparam logic [ADR_W-1:0] OFS_IEN_CLR = 8'h0C;
    localparam logic [ADR_W-1:0] OFS_MASK = 8'h10;

    // ------------------------------------------------------------
    // field layouts and reset values
    // ------------------------------------------------------------
    localparam int NSRC = 10;
    localparam logic [31:0] MODE_RESET = 32'h0000_0000;
    localparam logic [31:0] MODE_WMASK = 32'h0006_FFF0;
    localparam logic [NSRC-1:0] MASK_RESET = 10'h000;
    localparam int BIT_RX_AVAIL = 0;
    localparam int BIT_TX_FREE = 1;
    localparam int BIT_BREAK = 2;
    localparam int BIT_RX_DONE = 3;
    localparam int BIT_TX_DONE = 4;
    localparam int BIT_OVERRUN = 5;
    localparam int BIT_FRAMING = 6;
    localparam int BIT_CHECK = 7;
    localparam int BIT_TIMEOUT = 8;
    localparam int BIT_TX_IDLE = 9;

    // baud source codes and divide ratio
    localparam logic [1:0] SRC_MCK = 2'h0;
    localparam logic [1:0] SRC_DIV8 = 2'h1;
    localparam logic [2:0] DIV8_LAST = 3'h7;

    // character length and stop-bit codes
    localparam logic [3:0] CHAR_BASE = 4'h5;
    localparam logic [3:0] CHAR_NINE = 4'h9;
    localparam logic [1:0] STOP_ONE = 2'h0;
    localparam logic [1:0] STOP_ONE_HALF = 2'h1;
    localparam logic [1:0] STOP_TWO = 2'h2;
    localparam logic [2:0] HALVES_ONE = 3'h2;
    localparam logic [2:0] HALVES_ONE_HALF = 3'h3;
    localparam logic [2:0] HALVES_TWO = 3'h4;

    typedef enum logic [1:0] {
        LOOP_NORMAL = 2'b00,
        LOOP_ECHO = 2'b01,
        LOOP_LOCAL = 2'b10,
        LOOP_REMOTE = 2'b11
    } loop_t;

    typedef enum logic [2:0] {
        CHK_EVEN = 3'b000,
        CHK_ODD = 3'b001,
        CHK_SPACE = 3'b010,
        CHK_MARK = 3'b011,
        CHK_NONE = 3'b100,
        CHK_MULTIDROP = 3'b110
    } check_t;

    // mode register image, msb first
    typedef struct packed {
        logic [12:0] rsv_hi;
        logic clock_pin_drive;
        logic nine_bit_char_select;
        logic rsv_16;
        loop_t channel_loop_mode;
        logic [1:0] stop_bit_count;
        logic [2:0] check_bit_kind;
        logic sync_select;
        logic [1:0] char_length_field;
        logic [1:0] baud_source_select;
        logic [3:0] rsv_lo;
    } mode_cfg_t;

    // framing settings handed to the shift engines
    typedef struct packed {
        logic [3:0] data_bits;
        logic sync_mode;
        check_t check_kind;
        logic [2:0] stop_halves;
        logic stop_reserved;
    } frame_cfg_t;

endpackage : usart_mode_pkg

// ===== usart_remote_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// remote serial device on the far side of the pins
// ------------------------------------------------------------
module usart_remote_model (
    input wire logic clk_i,
    input wire logic run_i,
    output logic rxd_o,
    output logic sck_o
);
    logic [7:0] pat_q;
    logic [3:0] cnt_q;

    // idle line is high and the clock stands still low between frames
    initial begin
        pat_q = 8'hB2;
        cnt_q = 4'h0;
        rxd_o = 1'b1;
        sck_o = 1'b0;
    end

    // a frame shifts a bit every four cycles, clock period of eight cycles
    always @(posedge clk_i) begin
        if (!run_i) begin
            cnt_q <= 4'h0;
            rxd_o <= 1'b1;
            sck_o <= 1'b0;
        end else begin
            cnt_q <= cnt_q + 4'h1;
            sck_o <= cnt_q[2];
            if (cnt_q[1:0] == 2'h3) begin
                pat_q <= {pat_q[6:0], pat_q[7]};
                rxd_o <= pat_q[7];
            end
        end
    end
endmodule : usart_remote_model

// ===== test_usart_mode_irq.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// mode and interrupt mask bench
// ------------------------------------------------------------
module test_usart_mode_irq;
    import usart_mode_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic we = 1'b0;
    logic [ADR_W-1:0] adr = '0;
    logic [31:0] wdat = '0;
    logic [31:0] rdat;
    logic [31:0] rd;
    logic [NSRC-1:0] status_i = '0;
    logic tx_bit_i = 1'b0;
    logic run = 1'b0;
    logic ack, rxd, sck, txd_o, sck_o, sck_oe_o, rx_bit_o, baud_tick_o, tx_en, rx_en, xfer_en, irq_o;
    frame_cfg_t fc;
    mode_cfg_t m;
    logic [3:0] rh, th;
    int miscompares = 0;
    int comparisons = 0;
    int n;
    int f;
    logic [3:0] sel = 4'hF;

    // 40 MHz clock
    always #12.5 clk_i = ~clk_i;

    usart_mode_irq i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .status_i(status_i), .tx_bit_i(tx_bit_i), .rxd_i(rxd), .sck_i(sck), .txd_o(txd_o),
        .sck_o(sck_o), .sck_oe_o(sck_oe_o), .rx_bit_o(rx_bit_o), .baud_tick_o(baud_tick_o),
        .frame_cfg_o(fc), .tx_enable_o(tx_en), .rx_enable_o(rx_en), .xfer_enable_o(xfer_en),
        .irq_o(irq_o));

    usart_remote_model i_far (.clk_i(clk_i), .run_i(run), .rxd_o(rxd), .sck_o(sck));

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // one classic cycle; waits for ack under a bound, then idles a cycle
    task automatic bus(input logic w, input logic [ADR_W-1:0] a, input logic [31:0] d);
        int k;
        k = 0;
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk_i);
            k++;
        end while (ack !== 1'b1 && k < 16);
        if (k >= 16) check("ack", 1'b0, 1'b1);
        rd = rdat;
        cyc <= 1'b0;
        @(posedge clk_i);
    endtask : bus

    task automatic rdck(input logic [ADR_W-1:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        check("read data", rd, exp);
    endtask : rdck

    task automatic mode(input mode_cfg_t v);
        bus(1'b1, OFS_MODE, v);
        repeat (2) @(posedge clk_i);
    endtask : mode

    // pin routing by loop mode; the far side sends a frame meanwhile
    task automatic watch(input loop_t lm);
        m = '0;
        m.channel_loop_mode = lm;
        mode(m);
        run <= 1'b1;
        for (int k = 0; k < 40; k++) begin
            tx_bit_i <= k[0] ^ k[2];
            @(posedge clk_i);
            rh = {rh[2:0], rxd};
            th = {th[2:0], tx_bit_i};
            if (k > 4) begin
                case (lm)
                    LOOP_NORMAL: begin
                        check("txd normal", txd_o, th[1]);
                        check("rx bit normal", rx_bit_o, rh[3]);
                    end
                    LOOP_ECHO: begin
                        check("txd echo", txd_o, rh[3]);
                        check("rx bit echo", rx_bit_o, rh[3]);
                    end
                    LOOP_LOCAL: begin
                        check("rx bit local", rx_bit_o, th[1]);
                        check("txd local", txd_o, 1'b1);
                    end
                    default: begin
                        check("txd remote", txd_o, rh[3]);
                        check("rx bit remote", rx_bit_o, 1'b1);
                    end
                endcase
            end
        end
        if (lm == LOOP_NORMAL) check("enables", {tx_en, rx_en}, 2'b11);
        if (lm == LOOP_ECHO) check("enables", {tx_en, rx_en}, 2'b01);
        if (lm == LOOP_LOCAL) check("enables", {tx_en, rx_en}, 2'b11);
        if (lm == LOOP_REMOTE) check("enables", {tx_en, rx_en}, 2'b00);
        run <= 1'b0;
    endtask : watch

    // counts baud generator enables over a window once things settle
    task automatic ticks(input logic [1:0] src, input int exp);
        logic p;
        m = '0;
        m.baud_source_select = src;
        m.clock_pin_drive = 1'b1;
        mode(m);
        repeat (16) @(posedge clk_i);
        n = 0;
        f = 0;
        p = sck_o;
        // the pin clock flips once per internal tick and stands still on the external source
        repeat (64) begin
            @(posedge clk_i);
            n += (baud_tick_o === 1'b1);
            f += (sck_o !== p);
            p = sck_o;
        end
        check("baud ticks", n, exp);
        check("pin clock edges", f, src[1] ? 0 : exp);
        check("pin clock enable", sck_oe_o, !src[1]);
    endtask : ticks

    task automatic conclude;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : conclude

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rdck(OFS_MODE, 32'h0);
        rdck(OFS_MASK, 32'h0);
        bus(1'b1, OFS_MODE, 32'hFFFF_FFFF);
        rdck(OFS_MODE, 32'h0006_FFF0);
        // a single byte lane write touches only that lane
        sel <= 4'h2;
        bus(1'b1, OFS_MODE, 32'h0);
        sel <= 4'hF;
        rdck(OFS_MODE, 32'h0006_00F0);
        bus(1'b1, OFS_IEN_SET, 32'h0000_0205);
        rdck(OFS_MASK, 32'h0000_0205);
        bus(1'b1, OFS_IEN_SET, 32'h0000_00F0);
        rdck(OFS_MASK, 32'h0000_02F5);
        bus(1'b1, OFS_IEN_CLR, 32'h0000_0204);
        rdck(OFS_MASK, 32'h0000_00F1);
        rdck(OFS_IEN_SET, 32'h0);
        rdck(OFS_IEN_CLR, 32'h0);
        bus(1'b1, OFS_MASK, 32'hFFFF_FFFF);
        rdck(OFS_MASK, 32'h0000_00F1);
        rdck(8'h00, 32'h0);
        bus(1'b1, OFS_IEN_CLR, 32'hFFFF_FFFF);
        rdck(OFS_MASK, 32'h0);
        // each source alone: other sources busy must not reach the line
        for (int i = 0; i < NSRC; i++) begin
            bus(1'b1, OFS_IEN_SET, 32'h1 << i);
            status_i <= ~(10'h1 << i);
            repeat (2) @(posedge clk_i);
            check("irq other", irq_o, 1'b0);
            status_i <= 10'h1 << i;
            repeat (2) @(posedge clk_i);
            check("irq own", irq_o, 1'b1);
            bus(1'b1, OFS_IEN_CLR, 32'h1 << i);
            check("irq off", irq_o, 1'b0);
            status_i <= '0;
        end
        for (int c = 0; c < 4; c++) begin
            m = '0;
            m.char_length_field = 2'(c);
            mode(m);
            check("data bits", fc.data_bits, 32'(c) + 5);
            check("xfer on", xfer_en, 1'b1);
        end
        m.nine_bit_char_select = 1'b1;
        mode(m);
        check("nine bits", fc.data_bits, 4'h9);
        check("xfer off", xfer_en, 1'b0);
        for (int k = 0; k < 8; k++) begin
            m = '0;
            m.check_bit_kind = 3'(k);
            mode(m);
            check("check kind", fc.check_kind, k[2] ? {k[2:1], 1'b0} : k[2:0]);
        end
        for (int s = 0; s < 8; s++) begin
            m = '0;
            m.sync_select = s[2];
            m.stop_bit_count = s[1:0];
            mode(m);
            check("sync", fc.sync_mode, s[2]);
            check("stop rsv", fc.stop_reserved, s[1:0] == 2'h3 || s[2:0] == 3'h5);
            if (s[1:0] != 2'h3 && s[2:0] != 3'h5) check("halves", fc.stop_halves, s[1:0] + 2);
        end
        watch(LOOP_NORMAL);
        watch(LOOP_ECHO);
        watch(LOOP_LOCAL);
        watch(LOOP_REMOTE);
        // the divisor lives outside this block; the bench never asks for bypass on the master clock
        ticks(2'h0, 64);
        ticks(2'h1, 8);
        run <= 1'b1;
        ticks(2'h2, 8);
        ticks(2'h3, 8);
        run <= 1'b0;
        m = '0;
        m.clock_pin_drive = 1'b1;
        mode(m);
        check("clock pin driven", sck_oe_o, 1'b1);
        m.baud_source_select = 2'h2;
        mode(m);
        check("clock pin free", sck_oe_o, 1'b0);
        bus(1'b1, OFS_IEN_SET, 32'h0000_03FF);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rdck(OFS_MASK, 32'h0);
        rdck(OFS_MODE, 32'h0);
        conclude();
    end

    // cuts a hang short well past the expected run length
    initial begin
        repeat (20000) @(posedge clk_i);
        miscompares++;
        conclude();
    end
endmodule : test_usart_mode_irq
